// ==== omc_pkg.sv ====
// omc_pkg: constants for the optical module control and status timing block.
// assumes a single 200 MHz clock; all times are converted to cycle counts here.
package omc_pkg;

  localparam int CLK_MHZ = 200;

  // times as printed, in their own units
  localparam int T_OFF_US       = 10;
  localparam int T_ON_MS        = 1;
  localparam int T_INIT_MS      = 300;
  localparam int T_FAULT_US     = 100;
  localparam int T_RESET_US     = 10;
  localparam int T_LOSS_ON_US   = 100;
  localparam int T_LOSS_OFF_US  = 100;
  localparam int T_RATESEL_US   = 10;
  localparam int F_SERIAL_KHZ   = 100;

  // cycle counts (longest times round down, least times round up)
  localparam int OFF_CYC     = T_OFF_US * CLK_MHZ;
  localparam int ON_CYC      = T_ON_MS * 1000 * CLK_MHZ;
  localparam int INIT_CYC    = T_INIT_MS * 1000 * CLK_MHZ;
  localparam int FAULT_CYC   = T_FAULT_US * CLK_MHZ;
  localparam int RESET_CYC   = T_RESET_US * CLK_MHZ;
  localparam int LOSS_ON_CYC = T_LOSS_ON_US * CLK_MHZ;
  localparam int LOSS_OFF_CYC = T_LOSS_OFF_US * CLK_MHZ;
  localparam int RATESEL_CYC = T_RATESEL_US * CLK_MHZ;
  localparam int SCL_MIN_CYC = (CLK_MHZ * 1000 + F_SERIAL_KHZ - 1) / F_SERIAL_KHZ;

  // own settle delays, well inside the limits above
  localparam int LASER_ON_SETTLE = 16;
  localparam int FILT_DEPTH      = 8;

  // register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ    = 4'h2;
  localparam logic [3:0] ADDR_MASK   = 4'h3;

  // ctrl bits
  localparam int CTRL_SOFT_OFF = 0;
  localparam int CTRL_FAULT_INJ = 1;

  // status bits
  localparam int ST_LASER_ON  = 0;
  localparam int ST_FAULT     = 1;
  localparam int ST_LOS       = 2;
  localparam int ST_INIT_DONE = 3;
  localparam int ST_RATE_OK   = 4;
  localparam int ST_RATE_SEL  = 5;

  // interrupt bits
  localparam int IRQ_FAULT    = 0;
  localparam int IRQ_LOS_ON   = 1;
  localparam int IRQ_LOS_OFF  = 2;
  localparam int IRQ_INIT     = 3;
  localparam int IRQ_W        = 4;

  typedef enum logic [1:0] {
    OMC_INIT,
    OMC_OFF,
    OMC_RAMP,
    OMC_ON
  } omc_laser_e;

endpackage

// ==== omc_filter.sv ====
// omc_filter: debounce of a level that must stay stable for a number of cycles.
// assumes the input is already synchronous to mclk.
`timescale 1ns/100ps
module omc_filter
  import omc_pkg::*;
#(
  parameter int DEPTH = FILT_DEPTH
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // level in and filtered out
  input  wire logic din,
  output logic      dout_ff
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [CW-1:0] cnt_ff;

  initial begin
    if (DEPTH < 1) $error("omc_filter depth must be at least 1");
  end

  // a change must persist DEPTH cycles before it shows; short glitches are ignored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff  <= '0;
      dout_ff <= 1'b0;
    end else if (din == dout_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff == CW'(DEPTH - 1)) begin
      cnt_ff  <= '0;
      dout_ff <= din;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

endmodule

// ==== omc_ctrl.sv ====
// omc_ctrl: control and status timing of a pluggable optical module.
// assumes all inputs synchronous to mclk; the laser driver and receiver front end are outside.
//
// Notes on behaviour
// - after the laser off request rises the laser enable drops within the off time limit.
// - after a laser off request shorter than the reset time falls modulated light is on within the on time limit; a longer one restarts initialisation first.
// - initialisation, including fault flag clear, ends within the init limit after power-on or a fault clear.
// - a transmitter fault outside initialisation sets the fault flag within the fault assert limit.
// - a laser off request held high for at least the reset time clears a latched fault.
// - entering the loss state raises the signal lost flag within the loss assert limit.
// - leaving the loss state lowers the signal lost flag within the loss deassert limit.
// - the receiver bandwidth follows either edge of bandwidth select within the rate change limit.
`timescale 1ns/100ps
module omc_ctrl
  import omc_pkg::*;
#(
  parameter int INIT_CYCLES  = INIT_CYC,
  parameter int ON_CYCLES    = ON_CYC,
  parameter int RESET_CYCLES = RESET_CYC,
  parameter int SETTLE       = LASER_ON_SETTLE
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // host control pins
  input  wire logic       laser_off_req,
  input  wire logic       bw_select,
  input  wire logic       mgmt_clk,
  // analog front end status
  input  wire logic       laser_fault_det,
  input  wire logic       rx_loss_det,
  // module status pins, open drain: drive low when enable high
  output logic            tx_fault_o,
  output logic            tx_fault_oe,
  output logic            rx_lost_o,
  output logic            rx_lost_oe,
  // laser and receiver control, management clock error flag
  output logic            laser_en_ff,
  output logic            rx_bw_high_ff,
  output logic            mgmt_clk_err_ff,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_ff,
  // interrupt
  output logic            irq
);

  // each counter is sized for its own end value so that no compare constant is cut short
  localparam int CNTW  = $clog2(INIT_CYCLES + 1);
  localparam int RSTW  = $clog2(RESET_CYCLES + 1);
  localparam int BWW   = $clog2(RATESEL_CYC + 1);
  localparam int SCLW  = $clog2(SCL_MIN_CYC + 1);
  localparam int CTRLW = CTRL_FAULT_INJ + 1;
  localparam int STW   = ST_RATE_SEL + 1;

  initial begin
    if (INIT_CYCLES < 1 || ON_CYCLES < SETTLE + 1 || RESET_CYCLES < 1)
      $error("omc_ctrl timing parameters out of range");
    if (CNTW > 32 || FAULT_CYC < FILT_DEPTH + 2 || LOSS_ON_CYC < FILT_DEPTH + 2)
      $error("omc_ctrl filter too slow for limits");
    if (SETTLE < 1 || SETTLE > INIT_CYCLES)
      $error("omc_ctrl settle count must fit the init timer");
    if (RATESEL_CYC < 2 || SCL_MIN_CYC < 2)
      $error("omc_ctrl rate or serial clock count too small");
    if (STW > 8 || IRQ_W > 8 || CTRLW > 8)
      $error("omc_ctrl register fields wider than the data port");
  end

  omc_laser_e        state_ff;
  omc_laser_e        nxt_state;
  logic [CNTW-1:0]   tmr_ff;
  logic [RSTW-1:0]   off_cnt_ff;
  logic              fault_ff;
  logic              clear_pulse;
  logic              off_req_d_ff;
  logic              rx_lost_ff;
  logic              los_filt;
  logic              bw_d_ff;
  logic [BWW-1:0]    bw_cnt_ff;
  logic              rate_ok_ff;
  logic              mclk_d_ff;
  logic [SCLW-1:0]   scl_cnt_ff;
  logic [CTRLW-1:0]  ctrl_ff;
  logic [IRQ_W-1:0]  irq_st_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;
  logic [IRQ_W-1:0]  irq_ev;
  logic              off_total;
  logic              init_done;
  logic              fault_in;
  logic [STW-1:0]    status_word;

  assign off_total = laser_off_req | ctrl_ff[CTRL_SOFT_OFF];
  assign fault_in  = laser_fault_det | ctrl_ff[CTRL_FAULT_INJ];
  assign init_done = (state_ff != OMC_INIT);

  // loss detector is filtered; the filter depth is tiny against the 100 us limits
  omc_filter #(
    .DEPTH (FILT_DEPTH)
  ) u_los_filt (
    .mclk    (mclk),
    .rstn    (rstn),
    .din     (rx_loss_det),
    .dout_ff (los_filt)
  );

  // width of the high phase of the off request, used to recognise a fault clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      off_cnt_ff   <= '0;
      off_req_d_ff <= 1'b0;
    end else begin
      off_req_d_ff <= laser_off_req;
      if (!laser_off_req)
        off_cnt_ff <= '0;
      else if (off_cnt_ff != RSTW'(RESET_CYCLES))
        off_cnt_ff <= off_cnt_ff + RSTW'(1);
    end
  end

  // clear fires on the falling edge of a long enough pulse
  assign clear_pulse = off_req_d_ff & ~laser_off_req & (off_cnt_ff == RSTW'(RESET_CYCLES));

  // latched fault; a new fault in the clear cycle wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      fault_ff <= 1'b0;
    else if (fault_in && state_ff != OMC_INIT)
      fault_ff <= 1'b1;
    else if (clear_pulse)
      fault_ff <= 1'b0;
  end

  // laser state machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      OMC_INIT: begin
        if (tmr_ff == CNTW'(INIT_CYCLES - 1))
          nxt_state = OMC_OFF;
      end
      OMC_OFF: begin
        if (clear_pulse)
          nxt_state = OMC_INIT;
        else if (!off_total && !fault_ff)
          nxt_state = OMC_RAMP;
      end
      OMC_RAMP: begin
        if (off_total || fault_ff || fault_in)
          nxt_state = OMC_OFF;
        else if (tmr_ff == CNTW'(SETTLE - 1))
          nxt_state = OMC_ON;
      end
      OMC_ON: begin
        if (off_total || fault_ff || fault_in)
          nxt_state = OMC_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= OMC_INIT;
      tmr_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff)
        tmr_ff <= '0;
      else if (tmr_ff != CNTW'(INIT_CYCLES))
        tmr_ff <= tmr_ff + CNTW'(1);
    end
  end

  // laser is driven only in ramp and on; it drops one cycle after the request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      laser_en_ff <= 1'b0;
    else
      laser_en_ff <= (nxt_state == OMC_RAMP) || (nxt_state == OMC_ON);
  end

  // loss flag follows the filtered detector
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      rx_lost_ff <= 1'b1;
    else if (los_filt)
      rx_lost_ff <= 1'b1;
    else
      rx_lost_ff <= 1'b0;
  end

  // bandwidth switch: applied next cycle, conformance reported after the change time
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bw_d_ff       <= 1'b0;
      rx_bw_high_ff <= 1'b0;
      bw_cnt_ff     <= '0;
      rate_ok_ff    <= 1'b1;
    end else begin
      bw_d_ff       <= bw_select;
      rx_bw_high_ff <= bw_select;
      if (bw_select != bw_d_ff) begin
        bw_cnt_ff  <= '0;
        rate_ok_ff <= 1'b0;
      end else if (!rate_ok_ff) begin
        bw_cnt_ff <= bw_cnt_ff + BWW'(1);
        if (bw_cnt_ff == BWW'(RATESEL_CYC - 2))
          rate_ok_ff <= 1'b1;
      end
    end
  end

  // management clock watch: flags rising edges closer than the minimum period
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mclk_d_ff       <= 1'b0;
      // no edge seen yet counts as a full period, so the first host edge is never flagged
      scl_cnt_ff      <= SCLW'(SCL_MIN_CYC);
      mgmt_clk_err_ff <= 1'b0;
    end else begin
      mclk_d_ff <= mgmt_clk;
      if (mgmt_clk && !mclk_d_ff) begin
        scl_cnt_ff <= '0;
        if (scl_cnt_ff < SCLW'(SCL_MIN_CYC - 1))
          mgmt_clk_err_ff <= 1'b1;
      end else if (scl_cnt_ff != SCLW'(SCL_MIN_CYC)) begin
        scl_cnt_ff <= scl_cnt_ff + SCLW'(1);
      end
    end
  end

  // open-drain pins: drive low when the flag is clear, release to the pull-up when set
  assign tx_fault_o  = 1'b0;
  assign tx_fault_oe = ~fault_ff;
  assign rx_lost_o   = 1'b0;
  assign rx_lost_oe  = ~rx_lost_ff;

  // interrupt events
  assign irq_ev[IRQ_FAULT]   = fault_in && !fault_ff && init_done;
  assign irq_ev[IRQ_LOS_ON]  = los_filt && !rx_lost_ff;
  assign irq_ev[IRQ_LOS_OFF] = !los_filt && rx_lost_ff;
  assign irq_ev[IRQ_INIT]    = (state_ff == OMC_INIT) && (nxt_state == OMC_OFF);

  // control and mask registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff     <= '0;
      irq_mask_ff <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CTRL)
        ctrl_ff <= reg_wdata[CTRLW-1:0];
      if (reg_addr == ADDR_MASK)
        irq_mask_ff <= reg_wdata[IRQ_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event in the same cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
          irq_st_ff[gi] <= 1'b0;
        else if (irq_ev[gi])
          irq_st_ff[gi] <= 1'b1;
        else if (reg_wr && reg_addr == ADDR_IRQ && reg_wdata[gi])
          irq_st_ff[gi] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(irq_st_ff & irq_mask_ff);

  // status word, one flag per named bit position
  always_comb begin
    status_word               = '0;
    status_word[ST_LASER_ON]  = laser_en_ff;
    status_word[ST_FAULT]     = fault_ff;
    status_word[ST_LOS]       = rx_lost_ff;
    status_word[ST_INIT_DONE] = init_done;
    status_word[ST_RATE_OK]   = rate_ok_ff;
    status_word[ST_RATE_SEL]  = bw_select;
  end

  // read data stands in the cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL:   reg_rdata_ff <= 8'(ctrl_ff);
        ADDR_STATUS: reg_rdata_ff <= 8'(status_word);
        ADDR_IRQ:    reg_rdata_ff <= 8'(irq_st_ff);
        ADDR_MASK:   reg_rdata_ff <= 8'(irq_mask_ff);
        default:     reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

endmodule

// ==== omc_ctrl_asserts.sv ====
// omc_ctrl_asserts: pin-level checker for omc_ctrl.
// assumes one mclk domain; bound into every omc_ctrl instance.
`timescale 1ns/100ps
module omc_ctrl_chk
  import omc_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // inputs
  input wire logic       laser_off_req,
  input wire logic       bw_select,
  input wire logic       laser_fault_det,
  input wire logic       rx_loss_det,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  // outputs
  input wire logic       tx_fault_oe,
  input wire logic       rx_lost_oe,
  input wire logic       laser_en_ff,
  input wire logic       rx_bw_high_ff,
  input wire logic       mgmt_clk_err_ff,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic       irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  laser_off_a: assert property (laser_off_req |=> !laser_en_ff)
    else $error("laser enabled after off request");
  fault_off_a: assert property (!tx_fault_oe && !$past(tx_fault_oe) |-> !laser_en_ff)
    else $error("laser enabled during fault");
  fault_set_a: assert property (laser_en_ff && laser_fault_det |-> ##[1:2] !tx_fault_oe)
    else $error("fault flag late");
  fault_hold_a: assert property ((!laser_off_req)[*4] ##0 !tx_fault_oe |=> !tx_fault_oe)
    else $error("fault flag cleared without off pulse");
  loss_on_a: assert property (rx_loss_det[*8] |-> ##[0:4] !rx_lost_oe)
    else $error("loss flag late");
  loss_off_a: assert property ((!rx_loss_det)[*8] |-> ##[0:4] rx_lost_oe)
    else $error("loss flag not released");
  bw_follow_a: assert property ($changed(bw_select) |=> rx_bw_high_ff == $past(bw_select))
    else $error("bandwidth does not follow select");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
    else $error("read data outside read cycle");
  irq_mask_a: assert property (reg_wr && reg_addr == ADDR_MASK && reg_wdata == 8'h00 |=> !irq)
    else $error("interrupt with mask cleared");
  err_sticky_a: assert property (mgmt_clk_err_ff |=> mgmt_clk_err_ff)
    else $error("serial clock error not sticky");
  cover property (!tx_fault_oe);
  cover property ($fell(rx_lost_oe));
  cover property ($rose(laser_en_ff));
endmodule
bind omc_ctrl omc_ctrl_chk omc_ctrl_chk_i (.mclk, .rstn, .laser_off_req, .bw_select, .laser_fault_det,
  .rx_loss_det, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .tx_fault_oe, .rx_lost_oe, .laser_en_ff,
  .rx_bw_high_ff, .mgmt_clk_err_ff, .reg_rdata_ff, .irq);

// ==== omc_host_model.sv ====
// omc_host_model: host side source of the management serial clock.
// assumes mclk at 200 MHz; other host pins come from the bench.
`timescale 1ns/100ps
module omc_host_model
  import omc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // serial clock out
  output logic     mgmt_clk
);
  int cnt;
  // margin above the minimum half period so edges never come too close
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      mgmt_clk <= 1'b0;
    end else if (cnt == SCL_MIN_CYC / 2 + 10) begin
      cnt <= 0;
      mgmt_clk <= !mgmt_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== tb.sv ====
// tb: self-checking bench for omc_ctrl with short init and on counts.
// assumes the host model makes the serial clock; bench drives the rest.
`timescale 1ns/100ps
module tb
  import omc_pkg::*;
;
  localparam int INIT = 100;
  localparam int ONC  = 50;
  localparam int RSTC = 20;
  logic       mclk = 0, rstn = 0, laser_off_req = 0, bw_select = 0, laser_fault_det = 0, rx_loss_det = 0;
  logic       reg_wr = 0, reg_rd = 0, mgmt_clk, tx_fault_o, tx_fault_oe, rx_lost_o, rx_lost_oe, irq;
  logic       laser_en_ff, rx_bw_high_ff, mgmt_clk_err_ff;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata_ff;
  int         miscompares = 0, checks_done = 0;
  // open drain flags with host pull-ups
  wire        tx_fault_pin = tx_fault_oe ? tx_fault_o : 1'b1;
  wire        rx_lost_pin = rx_lost_oe ? rx_lost_o : 1'b1;
  always #2.5 mclk = !mclk;
  omc_ctrl #(.INIT_CYCLES(INIT), .ON_CYCLES(ONC), .RESET_CYCLES(RSTC), .SETTLE(LASER_ON_SETTLE)) omc_ctrl_i (
    .mclk, .rstn, .laser_off_req, .bw_select, .mgmt_clk, .laser_fault_det, .rx_loss_det, .tx_fault_o,
    .tx_fault_oe, .rx_lost_o, .rx_lost_oe, .laser_en_ff, .rx_bw_high_ff, .mgmt_clk_err_ff, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .irq);
  omc_host_model omc_host_model_i (.mclk, .rstn, .mgmt_clk);
  task results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // bounded wait on laser enable (0), fault pin (1) or loss pin (2)
  task wt(input int s, input logic v, input int n, input string m);
    logic g;
    g = ~v;
    for (int i = 0; i < n && g !== v; i++) begin
      @(posedge mclk);
      #1;
      g = s == 0 ? laser_en_ff : s == 1 ? tx_fault_pin : rx_lost_pin;
    end
    chk(g, v, m);
    if (g !== v) results;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_ff, e, m);
  endtask
  task t_off;
    @(posedge mclk);
    laser_off_req <= 1'b1;
    @(posedge mclk);
    #1;
    chk(laser_en_ff, 1'b0, "laser on after off request");
    @(posedge mclk);
    laser_off_req <= 1'b0;
    wt(0, 1'b1, ONC + LASER_ON_SETTLE + 10, "laser not back on");
    wr(ADDR_CTRL, 8'h01);
    wt(0, 1'b0, 3, "soft off ignored");
    wr(ADDR_CTRL, 8'h00);
    wt(0, 1'b1, ONC + LASER_ON_SETTLE + 10, "laser not on after soft off");
  endtask
  task t_bw;
    @(posedge mclk);
    bw_select <= 1'b1;
    @(posedge mclk);
    #1;
    chk(rx_bw_high_ff, 1'b1, "bandwidth not high");
    repeat (RATESEL_CYC + 20) @(posedge mclk);
    rd(ADDR_STATUS, 8'h39, "status after rate change");
    @(posedge mclk);
    bw_select <= 1'b0;
    @(posedge mclk);
    #1;
    chk(rx_bw_high_ff, 1'b0, "bandwidth not low");
  endtask
  task t_regs;
    rd(4'hF, 8'h00, "unmapped read");
    wr(4'hF, 8'hFF);
    wr(ADDR_IRQ, 8'h0F);
    rd(ADDR_IRQ, 8'h00, "events not cleared");
    wr(ADDR_MASK, 8'h0F);
    rd(ADDR_MASK, 8'h0F, "mask readback");
    chk(irq, 1'b0, "irq without event");
  endtask
  task t_fault;
    @(posedge mclk);
    laser_fault_det <= 1'b1;
    wt(1, 1'b1, FAULT_CYC, "fault flag not set");
    wt(0, 1'b0, 3, "laser on with fault");
    @(posedge mclk);
    laser_fault_det <= 1'b0;
    rd(ADDR_IRQ, 8'h01, "fault event missing");
    chk(irq, 1'b1, "irq not raised");
    wr(ADDR_MASK, 8'h00);
    #1;
    chk(irq, 1'b0, "irq not masked");
    wr(ADDR_MASK, 8'h0F);
    wr(ADDR_IRQ, 8'h01);
    #1;
    chk(irq, 1'b0, "irq not cleared");
    // a pulse below the reset time must leave the fault latched
    @(posedge mclk);
    laser_off_req <= 1'b1;
    repeat (5) @(posedge mclk);
    laser_off_req <= 1'b0;
    repeat (RSTC + 10) @(posedge mclk);
    #1;
    chk(tx_fault_pin, 1'b1, "fault cleared by short pulse");
    @(posedge mclk);
    laser_off_req <= 1'b1;
    repeat (RSTC + 2) @(posedge mclk);
    laser_off_req <= 1'b0;
    wt(1, 1'b0, 4, "fault not cleared by long pulse");
    wt(0, 1'b1, INIT + ONC + 40, "laser not on after re-init");
  endtask
  task t_loss;
    @(posedge mclk);
    rx_loss_det <= 1'b1;
    wt(2, 1'b1, LOSS_ON_CYC, "loss flag not set");
    @(posedge mclk);
    rx_loss_det <= 1'b0;
    wt(2, 1'b0, LOSS_OFF_CYC, "loss flag not released");
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    chk({laser_en_ff, tx_fault_oe, rx_lost_oe, irq}, 8'h04, "reset values");
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    wt(0, 1'b1, INIT + ONC + 40, "laser not on after init");
    t_off;
    t_bw;
    t_regs;
    t_fault;
    t_loss;
    chk(mgmt_clk_err_ff, 1'b0, "serial clock flagged");
    results;
  end
endmodule
